// [bench/t1cs_ext_src.sv]
`timescale 1ns/1ns
// external clock, crystal or sense oscillator; stands still between bursts
module t1cs_ext_src (
  // line level
  output logic lvl
);
  initial lvl = 1'b0;
  // one rising edge per pulse from either idle level; phases span many system clocks
  task automatic burst(input int n, input int half_ns);
    for (int i = 0; i < n; i++) begin
      #half_ns lvl = ~lvl;
      #half_ns lvl = ~lvl;
    end
  endtask
endmodule

// [bench/t1cs_properties.sv]
`timescale 1ns/1ns
// watches the top-level ports only; internal state is inferred from bus traffic
module t1cs_props (
  // clock and reset
  input wire       clk_sys,
  input wire       rst,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // pins and status
  input wire       pin0_oe_n,
  input wire       pin1_oe_n,
  input wire       timer_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a write to control or gate; status lags it by up to two cycles
  wire cfg_wr = reg_wr && reg_addr[2:1] == 2'b01;
  // run or gate cleared and not rewritten in the cycle after
  sequence s_run_off;
    reg_wr && reg_addr == 3'h2 && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 3'h2);
  endsequence
  sequence s_gate_off;
    reg_wr && reg_addr == 3'h3 && !reg_wdata[7] ##1 !(reg_wr && reg_addr == 3'h3);
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr[2:1] == 2'b11 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_run_stops: assert property (s_run_off |=> !timer_active)
    else $error("timer active with run bit clear");
  a_gate_stops: assert property (s_gate_off |=> !timer_active)
    else $error("timer active with gate bit clear");
  a_pins_input: assert property (timer_active |-> pin0_oe_n && pin1_oe_n)
    else $error("oscillator pin driven while enabled");
  a_port_zero: assert property (reg_rd && reg_addr == 3'h4 |=> !timer_active || reg_rdata[1:0] == 2'h0)
    else $error("port bits not zero while enabled");
  a_reset_quiet: assert property ($fell(rst) |-> !timer_active && pin0_oe_n && pin1_oe_n)
    else $error("outputs not idle after reset");
  a_active_cause: assert property ($rose(timer_active) |-> $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("timer enabled without a control write");
endmodule

bind t1cs_top t1cs_props u_props (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin0_oe_n(pin0_oe_n), .pin1_oe_n(pin1_oe_n), .timer_active(timer_active));

// [bench/timer1_counter_clock_select_bench.sv]
`timescale 1ns/1ns
// byte-port tests of the timer with modelled clock sources on its pins
module timer1_counter_clock_select_bench;
  reg        clk_sys = 1'b0;
  reg        rst = 1'b1;
  reg  [2:0] reg_addr = 3'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire       p0_o, p0_oe_n, p1_o, p1_oe_n, active, ext_lvl, xtal_lvl, cap_lvl;
  reg  [7:0] rdv;
  reg  [7:0] c0;
  int        fail_count = 0;
  int        checks_done = 0;
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  logic [7:0] rc [7] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'h09, 8'h49};
  int         rk [7] = '{8, 16, 16, 32, 16, 16, 8};
  logic [7:0] re [7] = '{8'h08, 8'h08, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08};
  logic [7:0] ec [4] = '{8'h84, 8'h80, 8'hC4, 8'h8C};

  always #25 clk_sys = ~clk_sys;

  // a driven pin reads back its own drive, else the source model's level
  t1cs_top u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin0_i(p0_oe_n ? ext_lvl : p0_o), .pin0_o(p0_o), .pin0_oe_n(p0_oe_n),
    .pin1_i(p1_oe_n ? xtal_lvl : p1_o), .pin1_o(p1_o), .pin1_oe_n(p1_oe_n),
    .cap_osc_in(cap_lvl), .timer_active(active));
  t1cs_ext_src u_ext (.lvl(ext_lvl));
  t1cs_ext_src u_xtal (.lvl(xtal_lvl));
  t1cs_ext_src u_cap (.lvl(cap_lvl));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write strobe then an idle cycle, so the strobe is never reassigned in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rdv = reg_rdata;
  endtask

  // increments of the low byte between two reads n cycles apart
  task automatic span(input int n);
    rd(3'h0);
    c0 = rdv;
    repeat (n - 2) @(posedge clk_sys);
    rd(3'h0);
    rdv = rdv - c0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rv[i]) begin
      rd(3'(i));
      if (i != 4) chk(rdv, rv[i]);
    end
    $display("reset values done");
    wr(3'h3, 8'h80);
    foreach (rc[i]) begin
      wr(3'h2, rc[i]);
      span(rk[i]);
      chk(rdv, re[i]);
    end
    wr(3'h3, 8'h00);
    span(8);
    chk(rdv, 8'h00);
    wr(3'h2, 8'h40);
    wr(3'h3, 8'h80);
    span(8);
    chk(rdv, 8'h00);
    $display("internal rates done");
    wr(3'h2, 8'h42);
    wr(3'h1, 8'hFF);
    wr(3'h0, 8'hFE);
    rd(3'h0);
    chk(rdv, 8'hFE);
    rd(3'h1);
    chk(rdv, 8'hFF);
    wr(3'h2, 8'h43);
    repeat (6) @(posedge clk_sys);
    wr(3'h2, 8'h42);
    rd(3'h0);
    chk({7'h00, rdv < 8'h10}, 8'h01);
    rd(3'h1);
    chk(rdv, 8'h00);
    wr(3'h2, 8'h40);
    wr(3'h1, 8'h55);
    wr(3'h0, 8'hFC);
    wr(3'h2, 8'h41);
    repeat (8) @(posedge clk_sys);
    wr(3'h2, 8'h40);
    rd(3'h1);
    chk(rdv, 8'h55);
    rd(3'h0);
    chk(rdv, 8'h06);
    $display("width and wrap done");
    // each source starting from either idle level; a high start must not count
    foreach (ec[i]) begin
      for (int j = 0; j < 2; j++) begin
        wr(3'h2, ec[i]);
        // the idle level must clear the synchroniser before the enable lands
        u_ext.lvl <= j[0];
        u_cap.lvl <= j[0];
        u_xtal.lvl <= j[0];
        wr(3'h0, 8'h00);
        wr(3'h2, ec[i] | 8'h01);
        repeat (4) @(posedge clk_sys);
        case (i)
          0, 1: u_ext.burst(3, 310);
          2: u_cap.burst(3, 310);
          default: u_xtal.burst(3, 310);
        endcase
        repeat (20) @(posedge clk_sys);
        wr(3'h2, ec[i]);
        rd(3'h0);
        chk(rdv, 8'h03);
      end
    end
    $display("external sources done");
    wr(3'h2, 8'h40);
    wr(3'h5, 8'h00);
    wr(3'h4, 8'hFF);
    repeat (4) @(posedge clk_sys);
    rd(3'h4);
    chk(rdv & 8'h03, 8'h03);
    wr(3'h2, 8'h41);
    repeat (4) @(posedge clk_sys);
    rd(3'h4);
    chk(rdv & 8'h03, 8'h00);
    chk({6'h00, p0_oe_n, p1_oe_n}, 8'h03);
    chk({7'h00, active}, 8'h01);
    $display("pin takeover done");
    finish_test();
  end

  // a hang ends the run as a mismatch
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
endmodule

// [src/t1cs_defines.vh]
`ifndef T1CS_DEFINES_VH
`define T1CS_DEFINES_VH

// register bus geometry
`define T1CS_AW 3
`define T1CS_DW 8

// register offsets (one byte each)
`define T1CS_A_CNT_LO 3'h0
`define T1CS_A_CNT_HI 3'h1
`define T1CS_A_CTRL   3'h2
`define T1CS_A_GATE   3'h3
`define T1CS_A_PORT   3'h4
`define T1CS_A_DIR    3'h5

// timer_control_reg fields
`define T1CS_SRC_HI   7
`define T1CS_SRC_LO   6
`define T1CS_PS_HI    5
`define T1CS_PS_LO    4
`define T1CS_OSCEN    3
`define T1CS_ASYNC    2
`define T1CS_WIDE     1
`define T1CS_RUN      0

// gate_control_reg fields
`define T1CS_GE       7

// clock_source_field encodings
`define T1CS_SRC_INSN 2'h0
`define T1CS_SRC_SYS  2'h1
`define T1CS_SRC_EXT  2'h2
`define T1CS_SRC_CAP  2'h3

// reset values
`define T1CS_CTRL_RST 8'h00
`define T1CS_GATE_RST 8'h00
`define T1CS_CNT_RST  16'h0000
`define T1CS_DIR_RST  2'h3
`define T1CS_PORT_RST 2'h0

// instruction clock is the system clock divided by four
`define T1CS_INSN_LAST 2'h3

// prescaler ratio masks for 1:1, 1:2, 1:4, 1:8
`define T1CS_PS_M1 3'h0
`define T1CS_PS_M2 3'h1
`define T1CS_PS_M4 3'h3
`define T1CS_PS_M8 3'h7

`endif

// [src/t1cs_sync.v]
`timescale 1ns/1ns
// two-flop synchroniser for asynchronous pin levels
module t1cs_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

// [src/t1cs_top.v]
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: incrementing counter, 8 or 16 bits wide, accessed as high and low bytes.
// RQ2: internal source makes a timer advancing once per instruction cycle.
// RQ3: external source advances the count on each selected edge of it.
// RQ4: counting needs both the run bit and the gate-enable bit set.
// RQ5: while enabled both oscillator pins are inputs and port reads give zero.
// RQ6: source 01 is system clock, 00 is instruction clock; oscillator bit ignored.
// RQ7: source 10 with oscillator bit clear counts the external clock pin.
// RQ8: source 10 with oscillator bit set counts the crystal oscillator circuit.
// RQ9: internal source rate is the system or instruction clock over the prescaler ratio.
// RQ10: external counting uses rising edges of pin or capacitive oscillator.
// RQ11: software picks synchronised or asynchronous external counting.
// RQ12: counter mode needs a falling edge before the first counted rising edge; here any low level arms it, even one already present at enable.
// RQ13: all-ones wraps to zero on the next increment and keeps counting.
`include "t1cs_defines.vh"

module t1cs_top (
  // clock and reset
  input  wire                 clk_sys,
  input  wire                 rst,
  // register port
  input  wire [`T1CS_AW-1:0]  reg_addr,
  input  wire [`T1CS_DW-1:0]  reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [`T1CS_DW-1:0]  reg_rdata,
  // pin 0: ext_clock_input and crystal_out_pin
  input  wire                 pin0_i,
  output reg                  pin0_o,
  output reg                  pin0_oe_n,
  // pin 1: crystal_in_pin
  input  wire                 pin1_i,
  output reg                  pin1_o,
  output reg                  pin1_oe_n,
  // capacitive sensing oscillator
  input  wire                 cap_osc_in,
  // status
  output reg                  timer_active
);

  // software state
  reg  [7:0]  timer_control_reg;
  reg  [7:0]  gate_control_reg;
  reg  [1:0]  port_direction_bits_reg;
  reg  [1:0]  port_latch_reg;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [7:0]  hi_wbuf_reg;
  reg  [7:0]  hi_rbuf_reg;

  // timing state
  reg  [1:0]  insn_div_reg;
  reg  [2:0]  pre_cnt_reg;
  reg  [2:0]  pre_cnt_next;
  reg         src_prev_reg;
  reg         armed_reg;
  reg         armed_next;
  reg         pend_reg;
  reg         pend_next;

  // combinational helpers
  wire [2:0]  pins_sync;
  wire        clk_pin_s;
  wire        xtal_in_s;
  wire        cap_s;
  wire [1:0]  src_sel;
  wire        osc_en;
  wire        async_en;
  wire        wide;
  wire        tmr_on;
  wire        ext_mode;
  wire        insn_tick;
  reg         src_lvl;
  reg  [2:0]  ps_mask;
  reg         raw_event;
  wire        ext_rise;
  wire        pre_tick;
  wire        wr_lo;
  wire        wr_hi;
  wire        cnt_write;
  reg  [7:0]  rd_mux;
  wire        pre_match;
  wire        cnt_clear;
  wire [1:0]  port_rd_val;

  // field decode of the control registers
  assign src_sel  = timer_control_reg[`T1CS_SRC_HI:`T1CS_SRC_LO];
  assign osc_en   = timer_control_reg[`T1CS_OSCEN];
  assign async_en = timer_control_reg[`T1CS_ASYNC];
  assign wide     = timer_control_reg[`T1CS_WIDE];
  assign ext_mode = src_sel[1];

  // both bits must be set before anything counts
  assign tmr_on = timer_control_reg[`T1CS_RUN] & gate_control_reg[`T1CS_GE]; // see RQ4

  // register write decode
  assign wr_lo     = reg_wr & (reg_addr == `T1CS_A_CNT_LO);
  assign wr_hi     = reg_wr & (reg_addr == `T1CS_A_CNT_HI);
  assign cnt_write = wr_lo | wr_hi; // either byte restarts edge detection

  // disable or a count write starts edge detection and prescaling afresh
  assign cnt_clear = ~tmr_on | cnt_write; // see RQ12

  // pins and capacitive oscillator come from outside the clock domain
  t1cs_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({cap_osc_in, pin1_i, pin0_i}),
    .sync_out (pins_sync)
  );

  assign clk_pin_s = pins_sync[0];
  assign xtal_in_s = pins_sync[1];
  assign cap_s     = pins_sync[2];

  // instruction clock enable: one pulse in every four system cycles
  assign insn_tick = (insn_div_reg == `T1CS_INSN_LAST); // see RQ6

  always @(posedge clk_sys) begin
    if (rst) begin
      insn_div_reg <= 2'h0;
    end else begin
      insn_div_reg <= insn_div_reg + 2'h1;
    end
  end

  // external level select; oscillator bit matters only for source 10
  always @* begin
    case (src_sel)
      `T1CS_SRC_EXT: src_lvl = osc_en ? xtal_in_s : clk_pin_s; // see RQ7 see RQ8
      `T1CS_SRC_CAP: src_lvl = cap_s; // see RQ10
      default:       src_lvl = 1'b0;
    endcase
  end

  // rising edge, honoured only once a low level has been seen
  assign ext_rise = ext_mode & src_lvl & ~src_prev_reg & armed_reg; // see RQ10 see RQ12

  // arming: dropped by reset, count writes or disable; set by a low input
  always @* begin
    armed_next = armed_reg;
    if (cnt_clear) begin
      armed_next = 1'b0; // see RQ12
    end else if (~src_lvl) begin
      armed_next = 1'b1; // see RQ12
    end
  end

  // synchronised mode holds an edge until the next instruction boundary
  always @* begin
    pend_next = pend_reg;
    if (cnt_clear | async_en) begin
      pend_next = 1'b0;
    end else if (insn_tick) begin
      pend_next = 1'b0;
    end else if (ext_rise) begin
      pend_next = 1'b1;
    end
  end

  // count events before the prescaler
  always @* begin
    case (src_sel)
      `T1CS_SRC_SYS:  raw_event = 1'b1; // see RQ6
      `T1CS_SRC_INSN: raw_event = insn_tick; // see RQ2
      default: begin
        if (async_en) begin
          raw_event = ext_rise; // see RQ11
        end else begin
          raw_event = insn_tick & (pend_reg | ext_rise); // see RQ11
        end
      end
    endcase
  end

  // prescaler ratio decode
  always @* begin
    case (timer_control_reg[`T1CS_PS_HI:`T1CS_PS_LO])
      2'h0:    ps_mask = `T1CS_PS_M1;
      2'h1:    ps_mask = `T1CS_PS_M2;
      2'h2:    ps_mask = `T1CS_PS_M4;
      default: ps_mask = `T1CS_PS_M8;
    endcase
  end

  // the counter moves once per full prescaler period
  assign pre_match = (pre_cnt_reg & ps_mask) == ps_mask; // stale phase ends early, no wrap
  assign pre_tick  = tmr_on & raw_event & pre_match; // see RQ9 see RQ3

  always @* begin
    pre_cnt_next = pre_cnt_reg;
    if (cnt_clear) begin
      pre_cnt_next = 3'h0; // a write also restarts the prescaler
    end else if (raw_event) begin
      if (pre_match) begin
        pre_cnt_next = 3'h0;
      end else begin
        pre_cnt_next = pre_cnt_reg + 3'h1;
      end
    end
  end

  // count value: a software write beats an increment in the same cycle
  always @* begin
    count_next = count_reg;
    if (wr_lo) begin
      count_next[7:0] = reg_wdata;
      if (wide) begin
        count_next[15:8] = hi_wbuf_reg; // see RQ1
      end
    end else if (wr_hi & ~wide) begin
      count_next[15:8] = reg_wdata; // see RQ1
    end else if (pre_tick) begin
      if (wide) begin
        count_next = count_reg + 16'h0001; // see RQ13
      end else begin
        count_next[7:0] = count_reg[7:0] + 8'h01; // see RQ1 see RQ13
      end
    end
  end

  // count value register
  always @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= `T1CS_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // prescaler phase restarts from zero on reset
  always @(posedge clk_sys) begin
    if (rst) begin
      pre_cnt_reg <= 3'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  // edge history, arming and the held synchronised edge
  always @(posedge clk_sys) begin
    if (rst) begin
      src_prev_reg <= 1'b0; // matches an idle-low pin, so no false edge
      armed_reg    <= 1'b0;
      pend_reg     <= 1'b0;
    end else begin
      src_prev_reg <= src_lvl;
      armed_reg    <= armed_next;
      pend_reg     <= pend_next;
    end
  end

  // control and port registers
  always @(posedge clk_sys) begin
    if (rst) begin
      timer_control_reg       <= `T1CS_CTRL_RST;
      gate_control_reg        <= `T1CS_GATE_RST;
      port_direction_bits_reg <= `T1CS_DIR_RST;
      port_latch_reg          <= `T1CS_PORT_RST;
      hi_wbuf_reg             <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `T1CS_A_CTRL: timer_control_reg       <= reg_wdata;
        `T1CS_A_GATE: gate_control_reg        <= reg_wdata;
        `T1CS_A_PORT: port_latch_reg          <= reg_wdata[1:0];
        `T1CS_A_DIR:  port_direction_bits_reg <= reg_wdata[1:0];
        `T1CS_A_CNT_HI: begin
          if (wide) begin
            hi_wbuf_reg <= reg_wdata; // high byte waits for the low write
          end
        end
        default: begin
        end
      endcase
    end
  end

  // an enabled timer owns both pins, so port reads see zero
  assign port_rd_val = tmr_on ? 2'h0 : {xtal_in_s, clk_pin_s}; // see RQ5

  // read mux; wide mode returns the high byte frozen at the low read
  always @* begin
    case (reg_addr)
      `T1CS_A_CNT_LO: rd_mux = count_reg[7:0];
      `T1CS_A_CNT_HI: rd_mux = wide ? hi_rbuf_reg : count_reg[15:8]; // see RQ1
      `T1CS_A_CTRL:   rd_mux = timer_control_reg;
      `T1CS_A_GATE:   rd_mux = gate_control_reg;
      `T1CS_A_PORT:   rd_mux = {6'h00, port_rd_val}; // see RQ5
      `T1CS_A_DIR:    rd_mux = {6'h00, port_direction_bits_reg};
      default:        rd_mux = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // high byte snapshot taken by every low-byte read
  always @(posedge clk_sys) begin
    if (rst) begin
      hi_rbuf_reg <= 8'h00;
    end else if (reg_rd & (reg_addr == `T1CS_A_CNT_LO)) begin
      hi_rbuf_reg <= count_reg[15:8]; // avoids a torn 16-bit read
    end
  end

  // status follows the enable one cycle late, like the pin enables
  always @(posedge clk_sys) begin
    if (rst) begin
      timer_active <= 1'b0;
    end else begin
      timer_active <= tmr_on;
    end
  end

  // pin 0: an enabled timer makes it an input whatever the direction bit says
  always @(posedge clk_sys) begin
    if (rst) begin
      pin0_o    <= 1'b0;
      pin0_oe_n <= 1'b1;
    end else begin
      pin0_o    <= port_latch_reg[0];
      pin0_oe_n <= tmr_on | port_direction_bits_reg[0]; // see RQ5
    end
  end

  // pin 1: same override; the crystal amplifier is an analog cell outside this block
  always @(posedge clk_sys) begin
    if (rst) begin
      pin1_o    <= 1'b0;
      pin1_oe_n <= 1'b1;
    end else begin
      pin1_o    <= port_latch_reg[1];
      pin1_oe_n <= tmr_on | port_direction_bits_reg[1]; // see RQ5
    end
  end

endmodule
